/* verilog/lsd_params.svh */
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH

// ****************************************
// configuration port
// ****************************************
`define LSD_IO_INDEX_PORT 16'h0022
`define LSD_IO_DATA_PORT 16'h0023
`define LSD_IDX_SHADOW_D 8'h26
`define LSD_IDX_SHADOW_E 8'h27
`define LSD_IDX_SHADOW_F 8'h28
`define LSD_IDX_VIDEO 8'h29
`define LSD_UNMAPPED_DATA 8'hFF

// ****************************************
// reset values
// ****************************************
`define LSD_RST_SHADOW 8'h00
`define LSD_RST_VIDEO 8'h03
`define LSD_RST_INDEX 8'h00

// ****************************************
// writable masks
// ****************************************
`define LSD_MASK_SHADOW_F 8'hE3
`define LSD_MASK_VIDEO 8'h3F

// ****************************************
// shadow f / smram fields
// ****************************************
`define LSD_F_SMRAM_SEL 7
`define LSD_F_CACHE_F 6
`define LSD_F_CACHE_C 5
`define LSD_F_RD_SHADOW 1
`define LSD_F_WR_SHADOW 0

// ****************************************
// video decode fields
// ****************************************
`define LSD_V_GCLK_STOP 5
`define LSD_V_PCLK_STOP 4
`define LSD_V_DCLK_STOP 3
`define LSD_V_PAL_SNOOP 2
`define LSD_V_VGA_EN 1
`define LSD_V_MOBO_MAP 0

// ****************************************
// address map, 16k granules
// ****************************************
`define LSD_ADDR_W 32
`define LSD_BLK_HI 31
`define LSD_BLK_LO 14
`define LSD_BLK_W 18
`define LSD_BLK_VGA_LO 18'h00028
`define LSD_BLK_VGA_HI 18'h0002F
`define LSD_BLK_C_LO 18'h00030
`define LSD_BLK_C_HI 18'h00031
`define LSD_BLK_D_LO 18'h00034
`define LSD_BLK_D_HI 18'h00037
`define LSD_BLK_E_LO 18'h00038
`define LSD_BLK_E_HI 18'h0003B
`define LSD_BLK_F_LO 18'h0003C
`define LSD_BLK_F_HI 18'h0003F
`define LSD_SUB_HI 15
`define LSD_SUB_LO 14

`endif

/* verilog/lsd_pkg.sv */
package lsd_pkg;

    `include "lsd_params.svh"

    typedef logic [7:0] lsd_byte_t;
    typedef logic [`LSD_ADDR_W-1:0] lsd_addr_t;

    typedef enum logic [4:0] {
        LSD_DST_NONE = 5'b00001,
        LSD_DST_SYSMEM = 5'b00010,
        LSD_DST_EXPANSION = 5'b00100,
        LSD_DST_SMRAM = 5'b01000,
        LSD_DST_VGA_FB = 5'b10000
    } lsd_dest_e;

    typedef struct packed {
        lsd_byte_t index_reg;
        lsd_byte_t shadow_d_reg;
        lsd_byte_t shadow_e_reg;
        lsd_byte_t shadow_f_reg;
        lsd_byte_t video_decode_reg;
        lsd_byte_t io_rdata_reg;
        logic io_rd_ack_reg;
        logic dec_valid_reg;
        logic route_sysmem_reg;
        logic route_expansion_reg;
        logic route_smram_reg;
        logic route_vga_fb_reg;
        logic cacheable_reg;
        logic rom_chip_select_n_reg;
        logic pal_update_reg;
        logic pal_to_pci_reg;
    } lsd_state_s;

endpackage

/* verilog/lsd_top.sv */
`timescale 1ns/1ps
`include "lsd_params.svh"
module lsd_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // configuration i/o port
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire lsd_pkg::lsd_byte_t io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rd_ack,
    // host memory cycle
    input wire logic mem_valid,
    input wire logic mem_write,
    input wire lsd_pkg::lsd_addr_t mem_addr,
    input wire logic smm_active,
    input wire logic c_seg_shadowed,
    input wire logic pal_write,
    // decode result
    output logic dec_valid,
    output logic route_sysmem,
    output logic route_expansion,
    output logic route_smram,
    output logic route_vga_fb,
    output logic cacheable,
    output logic rom_chip_select_n,
    output logic pal_update,
    output logic pal_to_pci,
    // video control
    output logic vga_enable,
    output logic vga_motherboard,
    output logic palette_snoop,
    output logic gclk_stop,
    output logic pclk_stop,
    output logic dclk_stop
);
    import lsd_pkg::*;

    // ****************************************
    // state
    // ****************************************
    localparam lsd_state_s RST_STATE = '{
        index_reg: `LSD_RST_INDEX,
        shadow_d_reg: `LSD_RST_SHADOW,
        shadow_e_reg: `LSD_RST_SHADOW,
        shadow_f_reg: `LSD_RST_SHADOW,
        video_decode_reg: `LSD_RST_VIDEO,
        io_rdata_reg: 8'h00,
        io_rd_ack_reg: 1'b0,
        dec_valid_reg: 1'b0,
        route_sysmem_reg: 1'b0,
        route_expansion_reg: 1'b0,
        route_smram_reg: 1'b0,
        route_vga_fb_reg: 1'b0,
        cacheable_reg: 1'b0,
        rom_chip_select_n_reg: 1'b1,
        pal_update_reg: 1'b0,
        pal_to_pci_reg: 1'b0
    };

    lsd_state_s state_reg;
    lsd_state_s state_next;

    // address class of the host cycle
    logic [`LSD_BLK_W-1:0] blk;
    logic [1:0] sub;
    logic in_vga;
    logic in_c_lo;
    logic in_d;
    logic in_e;
    logic in_f;

    // shadow attributes of the addressed block
    logic [7:0] seg_reg;
    logic rd_bit;
    logic wr_bit;
    logic shadowed;
    logic dir_shadow;

    // register read data and cycle destination
    logic [7:0] sel_data;
    lsd_dest_e dest;

    // ****************************************
    // address classification
    // ****************************************
    always_comb begin
        // block index counts 16k granules
        blk = mem_addr[`LSD_BLK_HI:`LSD_BLK_LO];
        sub = mem_addr[`LSD_SUB_HI:`LSD_SUB_LO];
        in_vga = (blk >= `LSD_BLK_VGA_LO) && (blk <= `LSD_BLK_VGA_HI);
        in_c_lo = (blk >= `LSD_BLK_C_LO) && (blk <= `LSD_BLK_C_HI);
        in_d = (blk >= `LSD_BLK_D_LO) && (blk <= `LSD_BLK_D_HI);
        in_e = (blk >= `LSD_BLK_E_LO) && (blk <= `LSD_BLK_E_HI);
        in_f = (blk >= `LSD_BLK_F_LO) && (blk <= `LSD_BLK_F_HI);
    end

    // ****************************************
    // shadow bit selection
    // ****************************************
    always_comb begin
        seg_reg = 8'h00;
        rd_bit = 1'b0;
        wr_bit = 1'b0;
        if (in_d) begin
            seg_reg = state_reg.shadow_d_reg;
        end else if (in_e) begin
            seg_reg = state_reg.shadow_e_reg;
        end
        if (in_d || in_e) begin
            // pair per 16k block, highest block in bits 7/6
            rd_bit = seg_reg[{sub, 1'b1}];
            wr_bit = seg_reg[{sub, 1'b0}];
        end else if (in_f) begin
            rd_bit = state_reg.shadow_f_reg[`LSD_F_RD_SHADOW];
            wr_bit = state_reg.shadow_f_reg[`LSD_F_WR_SHADOW];
        end
        dir_shadow = mem_write ? wr_bit : rd_bit;
        shadowed = rd_bit || wr_bit;
    end

    // ****************************************
    // destination select
    // ****************************************
    always_comb begin
        dest = LSD_DST_NONE;
        if (in_vga) begin
            // smram sits in system memory behind this window
            if (state_reg.shadow_f_reg[`LSD_F_SMRAM_SEL] || smm_active) begin
                dest = LSD_DST_SMRAM;
            end else begin
                dest = LSD_DST_VGA_FB;
            end
        end else if (in_d || in_e || in_f) begin
            if (dir_shadow) begin
                dest = LSD_DST_SYSMEM;
            end else begin
                dest = LSD_DST_EXPANSION;
            end
        end
    end

    // ****************************************
    // register read mux
    // ****************************************
    always_comb begin
        // unmapped indices read as all ones
        sel_data = `LSD_UNMAPPED_DATA;
        if (state_reg.index_reg == `LSD_IDX_SHADOW_D) begin
            sel_data = state_reg.shadow_d_reg;
        end else if (state_reg.index_reg == `LSD_IDX_SHADOW_E) begin
            sel_data = state_reg.shadow_e_reg;
        end else if (state_reg.index_reg == `LSD_IDX_SHADOW_F) begin
            sel_data = state_reg.shadow_f_reg;
        end else if (state_reg.index_reg == `LSD_IDX_VIDEO) begin
            sel_data = state_reg.video_decode_reg;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        state_next.io_rd_ack_reg = 1'b0;
        state_next.dec_valid_reg = 1'b0;
        state_next.pal_update_reg = 1'b0;
        state_next.pal_to_pci_reg = 1'b0;

        // ****************************************
        // index then data access
        // ****************************************
        if (io_wr) begin
            if (io_addr == `LSD_IO_INDEX_PORT) begin
                state_next.index_reg = io_wdata;
            end else if (io_addr == `LSD_IO_DATA_PORT) begin
                if (state_reg.index_reg == `LSD_IDX_SHADOW_D) begin
                    state_next.shadow_d_reg = io_wdata;
                end else if (state_reg.index_reg == `LSD_IDX_SHADOW_E) begin
                    state_next.shadow_e_reg = io_wdata;
                end else if (state_reg.index_reg == `LSD_IDX_SHADOW_F) begin
                    // reserved bits 4-2 stay zero
                    state_next.shadow_f_reg = io_wdata & `LSD_MASK_SHADOW_F;
                end else if (state_reg.index_reg == `LSD_IDX_VIDEO) begin
                    state_next.video_decode_reg = io_wdata & `LSD_MASK_VIDEO;
                end
            end
        end

        if (io_rd) begin
            state_next.io_rd_ack_reg = 1'b1;
            if (io_addr == `LSD_IO_INDEX_PORT) begin
                state_next.io_rdata_reg = state_reg.index_reg;
            end else if (io_addr == `LSD_IO_DATA_PORT) begin
                state_next.io_rdata_reg = sel_data;
            end else begin
                state_next.io_rdata_reg = `LSD_UNMAPPED_DATA;
            end
        end

        // ****************************************
        // memory cycle decode, one cycle latency
        // ****************************************
        if (mem_valid) begin
            state_next.dec_valid_reg = 1'b1;
            state_next.cacheable_reg = 1'b0;
            state_next.rom_chip_select_n_reg = 1'b1;
            // smram is reached over the memory path as well
            state_next.route_sysmem_reg = (dest == LSD_DST_SYSMEM) ||
                (dest == LSD_DST_SMRAM);
            state_next.route_expansion_reg = dest == LSD_DST_EXPANSION;
            state_next.route_smram_reg = dest == LSD_DST_SMRAM;
            state_next.route_vga_fb_reg = dest == LSD_DST_VGA_FB;
            if (in_vga) begin
                state_next.cacheable_reg = 1'b0;
            end else if (in_f) begin
                state_next.cacheable_reg = shadowed &&
                    state_reg.shadow_f_reg[`LSD_F_CACHE_F];
                // bios rom selected where f reads are not shadowed
                state_next.rom_chip_select_n_reg = mem_write || rd_bit;
            end else if (in_d || in_e) begin
                state_next.cacheable_reg = 1'b0;
            end else if (in_c_lo) begin
                state_next.cacheable_reg = c_seg_shadowed &&
                    state_reg.shadow_f_reg[`LSD_F_CACHE_C];
            end
        end

        // ****************************************
        // palette write handling
        // ****************************************
        // update always, pci copy only while snooping
        if (pal_write) begin
            state_next.pal_update_reg = 1'b1;
            state_next.pal_to_pci_reg =
                state_reg.video_decode_reg[`LSD_V_PAL_SNOOP];
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= RST_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        // configuration port
        io_rdata = state_reg.io_rdata_reg;
        io_rd_ack = state_reg.io_rd_ack_reg;

        // decode result; routes held until the next host cycle, dec_valid and palette strobes one cycle only
        dec_valid = state_reg.dec_valid_reg;
        route_sysmem = state_reg.route_sysmem_reg;
        route_expansion = state_reg.route_expansion_reg;
        route_smram = state_reg.route_smram_reg;
        route_vga_fb = state_reg.route_vga_fb_reg;
        cacheable = state_reg.cacheable_reg;
        rom_chip_select_n = state_reg.rom_chip_select_n_reg;
        pal_update = state_reg.pal_update_reg;
        pal_to_pci = state_reg.pal_to_pci_reg;

        // video control, straight register bits
        vga_enable = state_reg.video_decode_reg[`LSD_V_VGA_EN];
        vga_motherboard = state_reg.video_decode_reg[`LSD_V_MOBO_MAP];
        palette_snoop = state_reg.video_decode_reg[`LSD_V_PAL_SNOOP];
        gclk_stop = state_reg.video_decode_reg[`LSD_V_GCLK_STOP];
        pclk_stop = state_reg.video_decode_reg[`LSD_V_PCLK_STOP];
        dclk_stop = state_reg.video_decode_reg[`LSD_V_DCLK_STOP];
    end

endmodule

/* bench/lsd_monitor.sv */
`timescale 1ns/1ps
// ****************************************
// decode and port checks
// ****************************************
module lsd_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic io_rd_ack,
    input wire logic mem_valid,
    input wire lsd_pkg::lsd_addr_t mem_addr,
    input wire logic smm_active,
    input wire logic dec_valid,
    input wire logic route_sysmem,
    input wire logic route_expansion,
    input wire logic route_smram,
    input wire logic route_vga_fb,
    input wire logic cacheable,
    input wire logic pal_write,
    input wire logic pal_update,
    input wire logic pal_to_pci,
    input wire logic palette_snoop,
    input wire logic gclk_stop
);
    import lsd_pkg::*;
    wire logic seg_ab = mem_addr[31:17] == 15'h0005;
    wire logic seg_de = (mem_addr[31:16] == 16'h000D) || (mem_addr[31:16] == 16'h000E);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_ack;
        io_rd |=> io_rd_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("read ack missing");
    property p_dec;
        mem_valid |=> dec_valid;
    endproperty
    a_dec: assert property (p_dec) else $error("decode strobe missing");
    property p_de_nc;
        mem_valid && seg_de |=> !cacheable;
    endproperty
    a_de_nc: assert property (p_de_nc) else $error("d/e cacheable");
    property p_ab_nc;
        mem_valid && seg_ab |=> !cacheable && !route_expansion;
    endproperty
    a_ab_nc: assert property (p_ab_nc) else $error("a/b decode wrong");
    property p_smm;
        mem_valid && seg_ab && smm_active |=> route_smram && !route_vga_fb;
    endproperty
    a_smm: assert property (p_smm) else $error("smm not to smram");
    property p_excl;
        dec_valid |-> !(route_sysmem && route_expansion);
    endproperty
    a_excl: assert property (p_excl) else $error("two routes at once");
    property p_pal;
        pal_write |=> pal_update && (pal_to_pci == $past(palette_snoop));
    endproperty
    a_pal: assert property (p_pal) else $error("palette forward wrong");
    property p_stop;
        $changed(gclk_stop) |-> $past(io_wr) || $past(io_wr, 2);
    endproperty
    a_stop: assert property (p_stop) else $error("clock stop moved");
endmodule

bind lsd_top lsd_monitor i_mon (.core_clk, .reset, .io_rd, .io_wr, .io_rd_ack, .mem_valid,
    .mem_addr, .smm_active, .dec_valid, .route_sysmem, .route_expansion, .route_smram,
    .route_vga_fb, .cacheable, .pal_write, .pal_update, .pal_to_pci, .palette_snoop,
    .gclk_stop);

/* bench/lsd_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// host memory cycle source
// ****************************************
module lsd_host_model (
    input wire logic core_clk,
    output logic mem_valid,
    output logic mem_write,
    output lsd_pkg::lsd_addr_t mem_addr,
    output logic smm_active
);
    import lsd_pkg::*;
    initial begin
        mem_valid = 1'b0;
        mem_write = 1'b0;
        mem_addr = '0;
        smm_active = 1'b0;
    end
    task automatic cycle(input logic wr, input lsd_addr_t a, input logic smm);
        @(negedge core_clk);
        mem_valid = 1'b1;
        mem_write = wr;
        mem_addr = a;
        smm_active = smm;
        @(negedge core_clk);
        mem_valid = 1'b0;
        // released bus shows junk
        mem_addr = ~a;
        mem_write = ~wr;
    endtask
endmodule

/* bench/tb_lsd_top.sv */
`timescale 1ns/1ps
// ****************************************
// testbench
// ****************************************
module tb_lsd_top;
    import lsd_pkg::*;
    typedef struct packed {
        lsd_byte_t idx;
        lsd_byte_t val;
        logic wr;
        logic [19:0] a;
        logic smm;
        logic [3:0] rt;
        logic c;
        logic rn;
    } lsd_row_s;
    logic core_clk, reset, io_wr, io_rd, c_seg_shadowed, pal_write, io_rd_ack, dec_valid;
    logic [15:0] io_addr;
    lsd_byte_t io_wdata, d;
    logic [7:0] io_rdata;
    logic route_sysmem, route_expansion, route_smram, route_vga_fb, cacheable;
    logic rom_chip_select_n, pal_update, pal_to_pci, vga_enable, vga_motherboard;
    logic palette_snoop, gclk_stop, pclk_stop, dclk_stop, mem_valid, mem_write, smm_active;
    lsd_addr_t mem_addr;
    int err_count = 0;
    int comparisons = 0;
    lsd_row_s rows[12] = '{
        '{8'h26, 8'h80, 1'b0, 20'hDC000, 1'b0, 4'h8, 1'b0, 1'b1},
        '{8'h26, 8'h80, 1'b1, 20'hDC000, 1'b0, 4'h4, 1'b0, 1'b1},
        '{8'h26, 8'h01, 1'b1, 20'hD0000, 1'b0, 4'h8, 1'b0, 1'b1},
        '{8'h27, 8'h20, 1'b0, 20'hE8000, 1'b0, 4'h8, 1'b0, 1'b1},
        '{8'h27, 8'h20, 1'b0, 20'hEC000, 1'b0, 4'h4, 1'b0, 1'b1},
        '{8'h28, 8'h42, 1'b0, 20'hF0000, 1'b0, 4'h8, 1'b1, 1'b1},
        '{8'h28, 8'h40, 1'b0, 20'hFC000, 1'b0, 4'h4, 1'b0, 1'b0},
        '{8'h28, 8'h01, 1'b1, 20'hF8000, 1'b0, 4'h8, 1'b0, 1'b1},
        '{8'h28, 8'h80, 1'b0, 20'hA0000, 1'b0, 4'hA, 1'b0, 1'b1},
        '{8'h28, 8'h00, 1'b0, 20'hB0000, 1'b0, 4'h1, 1'b0, 1'b1},
        '{8'h28, 8'h00, 1'b1, 20'hA4000, 1'b1, 4'hA, 1'b0, 1'b1},
        '{8'h28, 8'h20, 1'b0, 20'hC4000, 1'b0, 4'h0, 1'b1, 1'b1}};
    lsd_top i_lsd_top (.core_clk, .reset, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
        .io_rd_ack, .mem_valid, .mem_write, .mem_addr, .smm_active, .c_seg_shadowed,
        .pal_write, .dec_valid, .route_sysmem, .route_expansion, .route_smram,
        .route_vga_fb, .cacheable, .rom_chip_select_n, .pal_update, .pal_to_pci,
        .vga_enable, .vga_motherboard, .palette_snoop, .gclk_stop, .pclk_stop, .dclk_stop);
    lsd_host_model i_lsd_host_model (.core_clk, .mem_valid, .mem_write, .mem_addr,
        .smm_active);
    task automatic chk(input string nm, input lsd_byte_t s, input lsd_byte_t e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic iow(input lsd_byte_t p, input lsd_byte_t v);
        @(negedge core_clk);
        io_wr = 1'b1;
        io_addr = {8'h00, p};
        io_wdata = v;
        @(negedge core_clk);
        io_wr = 1'b0;
        io_wdata = ~v;
    endtask
    task automatic ior(input lsd_byte_t p, output lsd_byte_t v);
        int k;
        @(negedge core_clk);
        io_rd = 1'b1;
        io_addr = {8'h00, p};
        @(negedge core_clk);
        io_rd = 1'b0;
        for (k = 0; k < 4 && io_rd_ack !== 1'b1; k++) begin
            @(negedge core_clk);
        end
        chk("ack", 8'(io_rd_ack), 8'h01);
        v = io_rdata;
    endtask
    task automatic cfg(input lsd_byte_t i, input lsd_byte_t v);
        iow(8'h22, i);
        iow(8'h23, v);
    endtask
    task automatic cfg_rd(input lsd_byte_t i, output lsd_byte_t v);
        iow(8'h22, i);
        ior(8'h23, v);
    endtask
    task automatic pal();
        @(negedge core_clk);
        pal_write = 1'b1;
        @(negedge core_clk);
        pal_write = 1'b0;
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #50000;
        err_count++;
        give_verdict();
    end
    initial begin
        {reset, io_wr, io_rd, io_addr, io_wdata} = {3'b100, 16'h0000, 8'h00};
        {c_seg_shadowed, pal_write} = 2'b10;
        repeat (3) @(negedge core_clk);
        reset = 1'b0;
        foreach (rows[i]) begin
            cfg(rows[i].idx, rows[i].val);
            i_lsd_host_model.cycle(rows[i].wr, {12'h000, rows[i].a}, rows[i].smm);
            chk("dec", 8'(dec_valid), 8'h01);
            chk("route", 8'({route_sysmem, route_expansion, route_smram, route_vga_fb}),
                8'(rows[i].rt));
            chk("cache", 8'(cacheable), 8'(rows[i].c));
            chk("rom_chip_select_n", 8'(rom_chip_select_n), 8'(rows[i].rn));
        end
        c_seg_shadowed = 1'b0;
        i_lsd_host_model.cycle(1'b0, 32'h000C0000, 1'b0);
        chk("c_cache", 8'(cacheable), 8'h00);
        cfg(8'h28, 8'hFF);
        cfg_rd(8'h28, d);
        chk("f_reg", d, 8'hE3);
        cfg(8'h29, 8'hFF);
        cfg_rd(8'h29, d);
        chk("video", d, 8'h3F);
        chk("stops", 8'({gclk_stop, pclk_stop, dclk_stop}), 8'h07);
        chk("snoop", 8'(palette_snoop), 8'h01);
        chk("vga_on", 8'({vga_enable, vga_motherboard}), 8'h03);
        pal();
        chk("pal_on", 8'({pal_update, pal_to_pci}), 8'h03);
        cfg(8'h29, 8'h00);
        pal();
        chk("pal_off", 8'({pal_update, pal_to_pci}), 8'h02);
        chk("vga", 8'({vga_enable, vga_motherboard}), 8'h00);
        chk("stops0", 8'({gclk_stop, pclk_stop, dclk_stop}), 8'h00);
        chk("snoop0", 8'(palette_snoop), 8'h00);
        cfg_rd(8'h2A, d);
        chk("unmapped", d, 8'hFF);
        ior(8'h40, d);
        chk("bad_port", d, 8'hFF);
        @(negedge core_clk);
        reset = 1'b1;
        @(negedge core_clk);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg_rd(8'h26 + 8'(i), d);
            chk("reset_val", d, (i == 3) ? 8'h03 : 8'h00);
        end
        chk("vga_rst", 8'({vga_enable, vga_motherboard}), 8'h03);
        give_verdict();
    end
endmodule
